// File: rtl/fifo_read_flags.sv
// dual-port fifo with read-side flags, read token ring and avalon registers
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
module fifo_read_flags
  import fifo_flags_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  input  wire logic                  CLOCK_I,
  input  wire logic                  ARST_N_I,
  input  wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [BUS_W-1:0]      AVS_WRITEDATA_I,
  input  wire logic [3:0]            AVS_BYTEENABLE_I,
  output logic      [BUS_W-1:0]      AVS_READDATA_O,
  output logic                       AVS_WAITREQUEST_O,
  input  wire logic                  READ_CLK_I,
  input  wire logic                  WRITE_CLK_I,
  input  wire logic                  READ_EN_N_I,
  input  wire logic                  WRITE_EN_N_I,
  input  wire logic [DATA_W-1:0]     WRITE_DATA_I,
  input  wire logic                  OUT_EN_N_I,
  input  wire logic                  READ_TOKEN_IN_N_I,
  input  wire logic                  WRITE_TOKEN_IN_N_I,
  input  wire logic                  FIRST_LOAD_SELECT_N_I,
  input  wire logic                  ENHANCED_MODE_SELECT_N_I,
  output logic      [DATA_W-1:0]     READ_DATA_O,
  output logic                       READ_DATA_OE_O,
  output logic                       EMPTY_INDICATOR_N_O,
  output logic                       ALMOST_EMPTY_INDICATOR_N_O,
  output logic                       FULL_INDICATOR_N_O,
  output logic                       ALMOST_FULL_INDICATOR_N_O,
  output logic                       READ_TOKEN_OUT_N_O,
  output logic                       WRITE_TOKEN_OUT_N_O
);

  localparam int PTR_W = $clog2(DEPTH);

  localparam logic [PTR_W:0]   DEPTH_CNT = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W:0]   OFS_RESET = (PTR_W+1)'(DEPTH / 8 - 1);
  localparam logic [PTR_W-1:0] LAST_LOC  = PTR_W'(DEPTH - 1);

  if (!(DEPTH == 512 || DEPTH == 1024)) begin : g_bad_depth
    $error("fifo_read_flags: DEPTH must be 512 or 1024");
  end

  typedef struct packed {
    pins_t            s1;
    pins_t            s2;
    logic             rd_clk_d;
    logic             wr_clk_d;
    logic             rtok_d;
    logic             wtok_d;
    logic [1:0]       rst_cnt;
    logic             strapped;
    mode_t            mode;
    logic [PTR_W:0]   wr_ptr;
    logic [PTR_W:0]   rd_ptr;
    logic             empty_n;
    logic             ae_n;
    logic             full_n;
    logic             af_n;
    logic             rd_active;
    logic             wr_active;
    logic             rd_pending;
    logic             wr_pending;
    logic             rtok_out_n;
    logic             wtok_out_n;
    logic [DATA_W-1:0] rdata;
    logic             oe;
    logic [BUS_W-1:0] ctrl;
    logic [PTR_W:0]   ae_ofs;
    logic [PTR_W:0]   af_ofs;
    logic             waitreq;
    logic [BUS_W-1:0] readdata;
  } state_t;

  localparam state_t STATE_RESET = '{
    s1 : PINS_IDLE, s2 : PINS_IDLE,
    rd_clk_d : 1'b0, wr_clk_d : 1'b0, rtok_d : 1'b1, wtok_d : 1'b1,
    rst_cnt : 2'h0, strapped : 1'b0, mode : MODE_STANDALONE,
    wr_ptr : '0, rd_ptr : '0,
    empty_n : 1'b0, ae_n : 1'b0, full_n : 1'b1, af_n : 1'b1,
    rd_active : 1'b0, wr_active : 1'b0,
    rd_pending : 1'b0, wr_pending : 1'b0,
    rtok_out_n : 1'b1, wtok_out_n : 1'b1,
    rdata : '0, oe : 1'b0,
    ctrl : CTRL_RESET, ae_ofs : OFS_RESET, af_ofs : OFS_RESET,
    waitreq : 1'b1, readdata : '0
  };

  logic [DATA_W-1:0] mem [DEPTH];

  state_t q;
  state_t next_q;

  pins_t             pins;
  logic              rd_tick;
  logic              wr_tick;
  logic              cascaded;
  logic              enhanced;
  logic              can_read;
  logic              can_write;
  logic [PTR_W:0]    next_rd_ptr;
  logic [PTR_W:0]    next_wr_ptr;
  logic [PTR_W:0]    cnt_rd;
  logic [PTR_W:0]    cnt_wr;
  logic [PTR_W:0]    cnt_now;
  logic [BUS_W-1:0]  status;
  logic [BUS_W-1:0]  bus_mask;
  logic [BUS_W-1:0]  merged;

  function automatic logic [PTR_W:0] clamp_ofs(input logic [BUS_W-1:0] v);
    clamp_ofs = (v > BUS_W'(DEPTH)) ? DEPTH_CNT : v[PTR_W:0];
  endfunction

  always_comb begin
    pins.rd_clk  = READ_CLK_I;
    pins.wr_clk  = WRITE_CLK_I;
    pins.rd_en_n = READ_EN_N_I;
    pins.wr_en_n = WRITE_EN_N_I;
    pins.oe_n    = OUT_EN_N_I;
    pins.wtok_n  = WRITE_TOKEN_IN_N_I;
    pins.rtok_n  = READ_TOKEN_IN_N_I;
    pins.fl_n    = FIRST_LOAD_SELECT_N_I;
    pins.enhanced_mode_select_n = ENHANCED_MODE_SELECT_N_I;
    pins.wdata   = WRITE_DATA_I;
  end

  // port clocks arrive as pins; each rising edge becomes a one-cycle tick
  assign rd_tick  = q.s2.rd_clk & ~q.rd_clk_d;
  assign wr_tick  = q.s2.wr_clk & ~q.wr_clk_d;
  assign cascaded = (q.mode == MODE_MASTER) || (q.mode == MODE_SLAVE);
  assign enhanced = (q.mode == MODE_PARALLEL);

  assign can_read  = rd_tick & ~q.s2.rd_en_n & q.empty_n & q.strapped
                     & (~cascaded | q.rd_active);
  assign can_write = wr_tick & ~q.s2.wr_en_n & q.full_n & q.strapped
                     & (~cascaded | q.wr_active);

  assign next_rd_ptr = q.rd_ptr + (PTR_W+1)'(can_read);
  assign next_wr_ptr = q.wr_ptr + (PTR_W+1)'(can_write);
  // read side sees only writes of earlier cycles
  assign cnt_rd  = q.wr_ptr - next_rd_ptr;
  // write side sees only reads of earlier cycles
  assign cnt_wr  = next_wr_ptr - q.rd_ptr;
  assign cnt_now = q.wr_ptr - q.rd_ptr;

  always_comb begin
    status = '0;
    status[ST_EMPTY_N]   = q.empty_n;
    status[ST_AE_N]      = q.ae_n;
    status[ST_FULL_N]    = q.full_n;
    status[ST_AF_N]      = q.af_n;
    status[ST_RD_ACTIVE] = q.rd_active;
    status[ST_WR_ACTIVE] = q.wr_active;
    status[ST_MODE_LSB +: 2] = q.mode;
    status[ST_COUNT_LSB +: PTR_W+1] = cnt_now;
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bus_mask[8*b +: 8] = {8{AVS_BYTEENABLE_I[b]}};
    end
  end

  always_comb begin
    next_q = q;
    merged = '0;
    next_q.s1       = pins;
    next_q.s2       = q.s1;
    next_q.rd_clk_d = q.s2.rd_clk;
    next_q.wr_clk_d = q.s2.wr_clk;
    next_q.rtok_d   = q.s2.rtok_n;
    next_q.wtok_d   = q.s2.wtok_n;
    next_q.rtok_out_n = 1'b1;
    next_q.wtok_out_n = 1'b1;

    // straps taken once synchroniser holds settled pin levels
    if (!q.strapped) begin
      if (q.rst_cnt == STRAP_CYCLE) begin
        next_q.strapped = 1'b1;
        if (!q.s2.enhanced_mode_select_n) begin
          next_q.mode = MODE_PARALLEL;
        end else if (q.s2.wtok_n && q.s2.rtok_n) begin
          next_q.mode = q.s2.fl_n ? MODE_SLAVE : MODE_MASTER;
        end else begin
          next_q.mode = MODE_STANDALONE;
        end
        next_q.rd_active = q.s2.enhanced_mode_select_n & q.s2.wtok_n & q.s2.rtok_n
                           & ~q.s2.fl_n;
        next_q.wr_active = next_q.rd_active;
      end else begin
        next_q.rst_cnt = q.rst_cnt + 2'h1;
      end
    end

    next_q.rd_ptr = next_rd_ptr;
    next_q.wr_ptr = next_wr_ptr;
    if (can_read) begin
      next_q.rdata = mem[q.rd_ptr[PTR_W-1:0]];
    end

    // word available at first read edge after rise
    if (rd_tick) begin
      next_q.empty_n = (cnt_rd != '0);
    end
    if (wr_tick) begin
      next_q.full_n = (cnt_wr != DEPTH_CNT);
    end

    // late write seen at next read edge
    if (enhanced && q.ctrl[CTRL_AE_SYNC]) begin
      if (rd_tick) begin
        next_q.ae_n = (cnt_rd > q.ae_ofs);
      end
    end else begin
      if (rd_tick && cnt_rd <= q.ae_ofs) begin
        next_q.ae_n = 1'b0;
      end
      if (wr_tick && cnt_wr > q.ae_ofs) begin
        next_q.ae_n = 1'b1;
      end
    end

    if (enhanced && q.ctrl[CTRL_AF_SYNC]) begin
      if (wr_tick) begin
        next_q.af_n = ((DEPTH_CNT - cnt_wr) > q.af_ofs);
      end
    end else begin
      if (wr_tick && (DEPTH_CNT - cnt_wr) <= q.af_ofs) begin
        next_q.af_n = 1'b0;
      end
      if (rd_tick && (DEPTH_CNT - cnt_rd) > q.af_ofs) begin
        next_q.af_n = 1'b1;
      end
    end

    if (cascaded && can_read && q.rd_ptr[PTR_W-1:0] == LAST_LOC) begin
      next_q.rtok_out_n = 1'b0;
      next_q.rd_active  = 1'b0;
    end
    if (cascaded && can_write && q.wr_ptr[PTR_W-1:0] == LAST_LOC) begin
      next_q.wtok_out_n = 1'b0;
      next_q.wr_active  = 1'b0;
    end

    // token in arms reading at next read edge
    if (rd_tick && q.rd_pending) begin
      next_q.rd_active  = 1'b1;
      next_q.rd_pending = 1'b0;
    end
    if (wr_tick && q.wr_pending) begin
      next_q.wr_active  = 1'b1;
      next_q.wr_pending = 1'b0;
    end
    // arrival beats a same-cycle clear so no token is lost
    if (cascaded && q.strapped && !q.s2.rtok_n && q.rtok_d) begin
      next_q.rd_pending = 1'b1;
    end
    if (cascaded && q.strapped && !q.s2.wtok_n && q.wtok_d) begin
      next_q.wr_pending = 1'b1;
    end

    // drive only when enabled and, in cascade modes, holding the token
    next_q.oe = ~q.s2.oe_n & (~cascaded | next_q.rd_active);

    // one wait cycle, then answer; write lands where waitrequest is low
    next_q.waitreq = 1'b1;
    if ((AVS_READ_I || AVS_WRITE_I) && q.waitreq) begin
      next_q.waitreq = 1'b0;
      case (AVS_ADDRESS_I)
        REG_CTRL:   next_q.readdata = q.ctrl;
        REG_AE_OFS: next_q.readdata = BUS_W'(q.ae_ofs);
        REG_AF_OFS: next_q.readdata = BUS_W'(q.af_ofs);
        REG_STATUS: next_q.readdata = status;
        default:    next_q.readdata = '0;
      endcase
    end
    if (AVS_WRITE_I && !q.waitreq) begin
      case (AVS_ADDRESS_I)
        REG_CTRL: begin
          merged = (q.ctrl & ~bus_mask) | (AVS_WRITEDATA_I & bus_mask);
          next_q.ctrl = '0;
          next_q.ctrl[CTRL_AE_SYNC] = merged[CTRL_AE_SYNC];
          next_q.ctrl[CTRL_AF_SYNC] = merged[CTRL_AF_SYNC];
        end
        REG_AE_OFS: begin
          merged = (BUS_W'(q.ae_ofs) & ~bus_mask)
                   | (AVS_WRITEDATA_I & bus_mask);
          next_q.ae_ofs = clamp_ofs(merged);
        end
        REG_AF_OFS: begin
          merged = (BUS_W'(q.af_ofs) & ~bus_mask)
                   | (AVS_WRITEDATA_I & bus_mask);
          next_q.af_ofs = clamp_ofs(merged);
        end
        default: begin
          merged = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= STATE_RESET;
    end else begin
      q <= next_q;
    end
  end

  // storage needs no reset; pointers decide what is valid
  always_ff @(posedge CLOCK_I) begin
    if (can_write) begin
      mem[q.wr_ptr[PTR_W-1:0]] <= q.s2.wdata;
    end
  end

  assign AVS_READDATA_O             = q.readdata;
  assign AVS_WAITREQUEST_O          = q.waitreq;
  assign READ_DATA_O                = q.rdata;
  assign READ_DATA_OE_O             = q.oe;
  assign EMPTY_INDICATOR_N_O        = q.empty_n;
  assign ALMOST_EMPTY_INDICATOR_N_O = q.ae_n;
  assign FULL_INDICATOR_N_O         = q.full_n;
  assign ALMOST_FULL_INDICATOR_N_O  = q.af_n;
  assign READ_TOKEN_OUT_N_O         = q.rtok_out_n;
  assign WRITE_TOKEN_OUT_N_O        = q.wtok_out_n;

endmodule // fifo_read_flags

// File: rtl/fifo_flags_pkg.sv
// constants, types and register map of the fifo read-side flag block
package fifo_flags_pkg;

  localparam int          DEPTH_DEF      = 512;
  localparam int          DATA_W         = 18;
  localparam int          BUS_W          = 32;
  localparam int          AVS_ADDR_W     = 5;

  // byte offsets of the register words
  localparam logic [4:0]  REG_CTRL       = 5'h00;
  localparam logic [4:0]  REG_AE_OFS     = 5'h04;
  localparam logic [4:0]  REG_AF_OFS     = 5'h08;
  localparam logic [4:0]  REG_STATUS     = 5'h0c;

  // control register fields
  localparam int          CTRL_AE_SYNC   = 1;
  localparam int          CTRL_AF_SYNC   = 4;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // status register fields
  localparam int          ST_EMPTY_N     = 0;
  localparam int          ST_AE_N        = 1;
  localparam int          ST_FULL_N      = 2;
  localparam int          ST_AF_N        = 3;
  localparam int          ST_RD_ACTIVE   = 4;
  localparam int          ST_WR_ACTIVE   = 5;
  localparam int          ST_MODE_LSB    = 6;
  localparam int          ST_COUNT_LSB   = 16;

  // cycles from reset release to strap capture
  localparam logic [1:0]  STRAP_CYCLE    = 2'h2;

  typedef enum logic [1:0] {
    MODE_STANDALONE = 2'b00,
    MODE_MASTER     = 2'b01,
    MODE_SLAVE      = 2'b10,
    MODE_PARALLEL   = 2'b11
  } mode_t;

  // pin inputs, carried together through the synchroniser
  typedef struct packed {
    logic              rd_clk;
    logic              wr_clk;
    logic              rd_en_n;
    logic              wr_en_n;
    logic              oe_n;
    logic              wtok_n;
    logic              rtok_n;
    logic              fl_n;
    logic              enhanced_mode_select_n;
    logic [DATA_W-1:0] wdata;
  } pins_t;

  localparam pins_t PINS_IDLE = '{
    rd_clk : 1'b0, wr_clk : 1'b0, rd_en_n : 1'b1, wr_en_n : 1'b1,
    oe_n : 1'b1, wtok_n : 1'b1, rtok_n : 1'b1, fl_n : 1'b1,
    enhanced_mode_select_n : 1'b1, wdata : 18'h00000
  };

endpackage

// File: tb/fifo_read_flags_checker.sv
// port assertions for the fifo read-side flag block
`timescale 1ns/1ns
module fifo_read_flags_checker
  import fifo_flags_pkg::*;
(
  input wire logic                  CLOCK_I,
  input wire logic                  ARST_N_I,
  input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic                  AVS_READ_I,
  input wire logic                  AVS_WRITE_I,
  input wire logic [BUS_W-1:0]      AVS_READDATA_O,
  input wire logic                  AVS_WAITREQUEST_O,
  input wire logic                  READ_CLK_I,
  input wire logic                  WRITE_CLK_I,
  input wire logic                  OUT_EN_N_I,
  input wire logic                  ENHANCED_MODE_SELECT_N_I,
  input wire logic [DATA_W-1:0]     READ_DATA_O,
  input wire logic                  READ_DATA_OE_O,
  input wire logic                  EMPTY_INDICATOR_N_O,
  input wire logic                  ALMOST_EMPTY_INDICATOR_N_O,
  input wire logic                  FULL_INDICATOR_N_O,
  input wire logic                  READ_TOKEN_OUT_N_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);

  a_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("late answer");
  a_wait_one: assert property (
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("long answer");
  a_unmapped_zero: assert property (!AVS_WAITREQUEST_O && AVS_READ_I &&
    AVS_ADDRESS_I > 5'h0c |-> AVS_READDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_reset_flags: assert property (
    $rose(ARST_N_I) |-> !EMPTY_INDICATOR_N_O && !ALMOST_EMPTY_INDICATOR_N_O
    && FULL_INDICATOR_N_O && READ_TOKEN_OUT_N_O) else $error("reset flags");
  a_empty_hold: assert property (
    !EMPTY_INDICATOR_N_O |=> $stable(READ_DATA_O))
    else $error("read while empty");
  a_empty_rise: assert property (
    $rose(EMPTY_INDICATOR_N_O) |-> $past(READ_CLK_I, 3) ||
    $past(READ_CLK_I, 4) || $past(READ_CLK_I, 5))
    else $error("empty rose without read edge");
  // standard strap only: the synchronous flag rises on read edges instead
  a_ae_rise: assert property (
    $rose(ALMOST_EMPTY_INDICATOR_N_O) && ENHANCED_MODE_SELECT_N_I |->
    $past(WRITE_CLK_I, 3) || $past(WRITE_CLK_I, 4) || $past(WRITE_CLK_I, 5))
    else $error("almost empty rose without write edge");
  a_token_pulse: assert property (
    $fell(READ_TOKEN_OUT_N_O) |=> READ_TOKEN_OUT_N_O)
    else $error("token pulse too long");
  a_token_hiz: assert property (
    !READ_TOKEN_OUT_N_O |-> ##[0:4] !READ_DATA_OE_O)
    else $error("drive kept after token out");
  a_oe_off: assert property (
    OUT_EN_N_I [*5] |-> !READ_DATA_OE_O) else $error("drive without enable");
endmodule // fifo_read_flags_checker

bind fifo_read_flags fifo_read_flags_checker fifo_read_flags_checker_inst (
  .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .READ_CLK_I(READ_CLK_I), .WRITE_CLK_I(WRITE_CLK_I),
  .OUT_EN_N_I(OUT_EN_N_I),
  .ENHANCED_MODE_SELECT_N_I(ENHANCED_MODE_SELECT_N_I),
  .READ_DATA_O(READ_DATA_O),
  .READ_DATA_OE_O(READ_DATA_OE_O), .EMPTY_INDICATOR_N_O(EMPTY_INDICATOR_N_O),
  .ALMOST_EMPTY_INDICATOR_N_O(ALMOST_EMPTY_INDICATOR_N_O),
  .FULL_INDICATOR_N_O(FULL_INDICATOR_N_O),
  .READ_TOKEN_OUT_N_O(READ_TOKEN_OUT_N_O));

// File: tb/fifo_port_partner.sv
// far side model: port clocks, strobes and the token ring
`timescale 1ns/1ns
module fifo_port_partner
  import fifo_flags_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              casc_i,
  input  wire logic              rtok_out_n_i,
  input  wire logic              wtok_out_n_i,
  output logic                   rclk_o,
  output logic                   wclk_o,
  output logic                   ren_n_o,
  output logic                   wen_n_o,
  output logic [DATA_W-1:0]      wdata_o,
  output logic                   rtok_n_o,
  output logic                   wtok_n_o
);
  logic [5:0] rhold = '0;
  logic [5:0] whold = '0;

  initial begin
    {rclk_o, wclk_o, ren_n_o, wen_n_o} = 4'h3;
    wdata_o = '0;
  end

  // other device keeps the token a while, then passes it back
  always_ff @(posedge clk_i) begin
    rhold <= !rtok_out_n_i ? 6'h28 : rhold - 6'(rhold != 0);
    whold <= !wtok_out_n_i ? 6'h28 : whold - 6'(whold != 0);
  end
  // standalone ring pins are tied low, cascade pins idle high
  assign rtok_n_o = casc_i ? !(rhold inside {6'h1, 6'h2, 6'h3}) : 1'b0;
  assign wtok_n_o = casc_i ? !(whold inside {6'h1, 6'h2, 6'h3}) : 1'b0;

  task automatic tick(input logic rd, input logic en_n,
                      input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    if (rd) begin
      ren_n_o <= en_n;
      rclk_o  <= 1'b1;
    end else begin
      wen_n_o <= en_n;
      wdata_o <= d;
      wclk_o  <= 1'b1;
    end
    repeat (6) @(posedge clk_i);
    rclk_o <= 1'b0;
    wclk_o <= 1'b0;
    // low phase, long enough for the synchroniser to see the fall before the next edge
    repeat (4) @(posedge clk_i);
  endtask
endmodule // fifo_port_partner

// File: tb/tb_fifo_read_flags.sv
// self-checking bench of the fifo read-side flag block
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb_fifo_read_flags
  import fifo_flags_pkg::*;
;
  localparam int DEPTH = 512;
  logic clock, arst_n, avs_rd, avs_wr, casc, oe_n, waitreq, q_oe, enhanced_mode_select_n;
  logic rclk, wclk, ren_n, wen_n, rtin_n, wtin_n, rto_n, wto_n;
  logic ef_n, ae_n, ff_n, af_n;
  logic [AVS_ADDR_W-1:0] avs_addr;
  logic [BUS_W-1:0]      avs_wdata, avs_rdata;
  logic [DATA_W-1:0]     wdata, q;
  logic [DATA_W-1:0]     mq[$];
  int fails, checks, toks, wtoks;

  fifo_read_flags #(.DEPTH(DEPTH)) fifo_read_flags_inst (
    .CLOCK_I(clock), .ARST_N_I(arst_n), .AVS_ADDRESS_I(avs_addr),
    .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr), .AVS_WRITEDATA_I(avs_wdata),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(avs_rdata),
    .AVS_WAITREQUEST_O(waitreq), .READ_CLK_I(rclk), .WRITE_CLK_I(wclk),
    .READ_EN_N_I(ren_n), .WRITE_EN_N_I(wen_n), .WRITE_DATA_I(wdata),
    .OUT_EN_N_I(oe_n), .READ_TOKEN_IN_N_I(rtin_n),
    .WRITE_TOKEN_IN_N_I(wtin_n), .FIRST_LOAD_SELECT_N_I(1'b0),
    .ENHANCED_MODE_SELECT_N_I(enhanced_mode_select_n), .READ_DATA_O(q),
    .READ_DATA_OE_O(q_oe),
    .EMPTY_INDICATOR_N_O(ef_n), .ALMOST_EMPTY_INDICATOR_N_O(ae_n),
    .FULL_INDICATOR_N_O(ff_n), .ALMOST_FULL_INDICATOR_N_O(af_n),
    .READ_TOKEN_OUT_N_O(rto_n), .WRITE_TOKEN_OUT_N_O(wto_n));

  fifo_port_partner fifo_port_partner_inst (
    .clk_i(clock), .casc_i(casc), .rtok_out_n_i(rto_n),
    .wtok_out_n_i(wto_n), .rclk_o(rclk), .wclk_o(wclk), .ren_n_o(ren_n),
    .wen_n_o(wen_n), .wdata_o(wdata), .rtok_n_o(rtin_n), .wtok_n_o(wtin_n));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(negedge rto_n) toks++;
  always @(negedge wto_n) wtoks++;

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic reset();
    arst_n <= 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask

  task automatic avs(input logic wr, input logic [AVS_ADDR_W-1:0] a,
                     input logic [BUS_W-1:0] d, output logic [BUS_W-1:0] r);
    int n;
    @(posedge clock);
    avs_addr  <= a;
    avs_wdata <= d;
    avs_wr    <= wr;
    avs_rd    <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      end_of_test();
    end
    r = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
  endtask

  task automatic wr(input logic [DATA_W-1:0] d);
    fifo_port_partner_inst.tick(1'b0, 1'b0, d);
    mq.push_back(d);
  endtask

  // popping only after empty was seen high keeps reads honest
  task automatic rd(input logic en_n);
    logic was;
    logic [DATA_W-1:0] e;
    was = ef_n;
    fifo_port_partner_inst.tick(1'b1, en_n, '0);
    if (was === 1'b1 && en_n === 1'b0 && mq.size() > 0) begin
      e = mq.pop_front();
      `CHK(q, e)
    end
  endtask

  initial begin
    logic [BUS_W-1:0] r;
    int n;
    fails = 0;
    checks = 0;
    {avs_rd, avs_wr, casc, oe_n, enhanced_mode_select_n} = 5'h01;
    avs_addr = '0;
    avs_wdata = '0;
    arst_n = 1'b0;
    void'($urandom(19));
    reset();
    `CHK({ef_n, ae_n, ff_n, af_n, rto_n, wto_n, q, q_oe}, {6'h0f, 18'h0, 1'b1})
    avs(1'b0, REG_AE_OFS, '0, r);
    `CHK(r, 32'(DEPTH / 8 - 1))
    avs(1'b0, 5'h14, '0, r);
    `CHK(r, 32'h0)
    avs(1'b1, REG_AE_OFS, 32'(DEPTH + 5), r);
    avs(1'b0, REG_AE_OFS, '0, r);
    `CHK(r, 32'(DEPTH))
    avs(1'b1, REG_AE_OFS, 32'h3, r);
    for (int i = 0; i < 5; i++) begin
      wr(DATA_W'($urandom));
      `CHK(ae_n, mq.size() > 3)
    end
    `CHK(ef_n, 1'b0)
    avs(1'b0, REG_STATUS, '0, r);
    `CHK({r[26:16], r[7:6]}, {11'd5, MODE_STANDALONE})
    rd(1'b1);
    `CHK(ef_n, 1'b1)
    for (int i = 0; i < 14; i++) rd(1'($urandom));
    repeat (6) rd(1'b0);
    `CHK({ef_n, ae_n, rto_n}, 3'h1)
    casc <= 1'b1;
    reset();
    toks = 0;
    wtoks = 0;
    avs(1'b0, REG_STATUS, '0, r);
    `CHK(r[7:6], MODE_MASTER)
    for (int i = 0; i < DEPTH; i++) wr(DATA_W'($urandom));
    `CHK({ff_n, af_n}, 2'h0)
    n = 0;
    while (mq.size() > 0 && n < DEPTH + 4) begin
      rd(1'b0);
      n++;
    end
    `CHK({toks, wtoks, mq.size()}, {32'd1, 32'd1, 32'd0})
    avs(1'b0, REG_STATUS, '0, r);
    `CHK({r[ST_RD_ACTIVE], q_oe}, 2'h0)
    // token comes back from the ring partner after its hold time
    repeat (50) @(posedge clock);
    rd(1'b1);
    avs(1'b0, REG_STATUS, '0, r);
    `CHK({r[ST_RD_ACTIVE], q_oe}, 2'h3)
    casc    <= 1'b0;
    enhanced_mode_select_n <= 1'b0;
    // read clock pin pulses once, high across the reset release
    fork
      reset();
      fifo_port_partner_inst.tick(1'b1, 1'b1, '0);
    join
    avs(1'b0, REG_STATUS, '0, r);
    `CHK(r[7:0], {MODE_PARALLEL, 6'h0c})
    avs(1'b1, REG_CTRL, 32'hffff_ffff, r);
    avs(1'b0, REG_CTRL, '0, r);
    `CHK(r, 32'h12)
    avs(1'b1, REG_AE_OFS, 32'h3, r);
    for (int i = 0; i < 4; i++) begin
      wr(DATA_W'($urandom));
      `CHK(ae_n, 1'b0)
    end
    rd(1'b1);
    `CHK({ef_n, ae_n}, 2'h3)
    oe_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK(q_oe, 1'b0)
    oe_n <= 1'b0;
    repeat (5) @(posedge clock);
    `CHK(q_oe, 1'b1)
    repeat (5) rd(1'b0);
    `CHK({ef_n, mq.size()}, {1'b0, 32'd0})
    end_of_test();
  end

  initial begin
    #2_000_000;
    fails++;
    end_of_test();
  end
endmodule // tb_fifo_read_flags
